// ---- verilog/gmc_map.vh ----
`ifndef GMC_MAP_VH
`define GMC_MAP_VH

// ==========================================================
// timing
`define GMC_CLK_HZ        100000000
`define GMC_BAUD          9600
`define GMC_TICK_MS       1000
`define GMC_DBG_WAIT_MS   500
`define GMC_SYNC_CYC      2'h3

// ==========================================================
// register byte offsets
`define GMC_REG_CTRL      5'h00
`define GMC_REG_STATUS    5'h04
`define GMC_REG_RXDATA    5'h08
`define GMC_REG_TXDATA    5'h0C

// ==========================================================
// fields and reset values
`define GMC_CTRL_FCHK     0
`define GMC_CTRL_RESET    1'h1
`define GMC_ST_MODE_LO    0
`define GMC_ST_MODE_HI    2
`define GMC_ST_FERR       3
`define GMC_ST_RXEMPTY    4
`define GMC_ST_TXFULL     5

// ==========================================================
// codes
`define GMC_SW_CONFIG     4'hF
`define GMC_SW_TEST       4'hE
`define GMC_HELLO_BYTE    8'h00
`define GMC_ACK_BYTE      8'h4F
`define GMC_REPLY_FILL    8'hFF
`define GMC_TCP_PORT      16'h0017
`define GMC_FERR_CODE     4'h1
`define GMC_BUF_AW        10
`define GMC_ETH_ECHO      6

`endif

// ---- verilog/gmc_top.v ----
`timescale 1ns/10ps
// Contract
// - both mode switches at F at power-up select configuration mode.
// - configuration mode uses 9600 8N1 serial and flashes the red status indicator.
// - configuration ethernet reply: echo, echo, zero, echo, FF, three version bytes.
// - ethernet offers four channels; TCP port 23 default; UDP scan dropped on FTP.
// - both mode switches at E after power restart select test mode.
// - test mode uses 9600 8N1 serial.
// - test mode sends 0..15 each second as ASCII hex and binary fieldbus value.
// - test mode error indicators show the value being sent, in binary.
// - test mode echoes each received character back on the same interface.
// - fieldbus echo looks only at byte one; other bytes unchanged.
// - test ethernet output is eight bytes, first six echo received data.
// - seventh test byte counts 0..255 each second and wraps.
// - eighth test byte counts 0..9 each second, cyclically.
// - test mode always uses TCP server port 23.
// - data exchange mode when no other mode; runs the script.
// - serial side has 1024-byte receive and 1024-byte transmit buffers.
// - stop-bit check applies only with eight data bits and no parity.
// - enabled check flags a stop bit shorter than one bit on error indicators; the code flags only the application line, and not in test mode.
// - stop-bit check enabled at reset and switchable by configuration.
// - after self-test send 0x00 on debug port; 0x4F within 500 ms enters debug.
// - entering debug mode stops script execution.
// - debug port always 9600 8N1 with no flow control.
`include "gmc_map.vh"

module gmc_top #(
  parameter BIT_CYC  = `GMC_CLK_HZ / `GMC_BAUD,
  parameter TICK_CYC = (`GMC_CLK_HZ / 1000) * `GMC_TICK_MS,
  parameter WAIT_CYC = (`GMC_CLK_HZ / 1000) * `GMC_DBG_WAIT_MS,
  parameter EXT_VER  = 24'h010203  // arbitrary value
) (
  input  wire        core_clk,
  input  wire        arst_n,
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire [3:0]  mode_switch_a,
  input  wire [3:0]  mode_switch_b,
  input  wire        app_rxd,
  output wire        app_txd,
  input  wire        dbg_rxd,
  output wire        dbg_txd,
  input  wire        fb_in_valid,
  input  wire [7:0]  fb_in_byte0,
  output reg         fb_out_valid,
  output reg  [7:0]  fb_out_byte0,
  input  wire        eth_rx_valid,
  input  wire        eth_rx_sof,
  input  wire [7:0]  eth_rx_data,
  input  wire        eth_ftp_connected,
  output reg  [63:0] eth_reply,
  output wire [15:0] eth_tcp_port,
  output wire        eth_udp_scan_en,
  output reg  [3:0]  error_number_indicators,
  output reg         serial_status_indicator,
  output reg         script_run,
  output wire [2:0]  mode
);

  localparam HALF_CYC = BIT_CYC / 2;
  localparam FMT_8N1  = 1'b1;
  // mode states
  localparam M_SYNC  = 3'h0;
  localparam M_CFG   = 3'h1;
  localparam M_TEST  = 3'h2;
  localparam M_DATA  = 3'h3;
  localparam M_DEBUG = 3'h4;
  localparam M_HELLO = 3'h5;
  localparam M_WAIT  = 3'h6;
  // receiver states
  localparam R_IDLE  = 2'h0;
  localparam R_START = 2'h1;
  localparam R_DATA  = 2'h2;
  localparam R_STOP  = 2'h3;

  function [7:0] hex_ascii;
    input [3:0] v;
    begin
      if (v < 4'hA)
        hex_ascii = 8'h30 + {4'h0, v};
      else
        hex_ascii = 8'h37 + {4'h0, v};
    end
  endfunction

  // ==========================================================
  // two serial channels: 0 application, 1 debug, both fixed 8N1
  wire [1:0]  rx_pin = {dbg_rxd, app_rxd};
  wire [1:0]  rx_done;
  wire [1:0]  rx_ferr;
  wire [15:0] rx_byte;
  wire [1:0]  tx_busy;
  wire [1:0]  tx_line;
  wire [1:0]  tx_go;
  wire [15:0] tx_byte;
  reg         dbg_go;
  reg         app_go;
  reg  [7:0]  app_tx_byte;

  // the debug channel only ever sends the hello byte
  assign tx_go   = {dbg_go, app_go};
  assign tx_byte = {`GMC_HELLO_BYTE, app_tx_byte};

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : g_uart
      reg        s1;
      reg        s2;
      reg [1:0]  rst;
      reg [15:0] rcnt;
      reg [2:0]  rbit;
      reg [7:0]  rsh;
      reg        rbad;
      reg        rdone;
      reg        rferr;
      reg [15:0] tcnt;
      reg [3:0]  tidx;
      reg [9:0]  tsh;
      reg        tbusy;
      always @(posedge core_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          s1    <= 1'b1;
          s2    <= 1'b1;
          rst   <= R_IDLE;
          rcnt  <= 16'h0000;
          rbit  <= 3'h0;
          rsh   <= 8'h00;
          rbad  <= 1'b0;
          rdone <= 1'b0;
          rferr <= 1'b0;
          tcnt  <= 16'h0000;
          tidx  <= 4'h0;
          tsh   <= 10'h3FF;
          tbusy <= 1'b0;
        end
        else
        begin
          s1    <= rx_pin[ch];
          s2    <= s1;
          rdone <= 1'b0;
          rferr <= 1'b0;
          rcnt  <= rcnt + 16'h0001;
          case (rst)
            R_IDLE:
            begin
              rcnt <= 16'h0000;
              if (!s2)
                rst <= R_START;
            end
            R_START:
              if (rcnt == HALF_CYC - 1)
              begin
                rcnt <= 16'h0000;
                rbit <= 3'h0;
                rst  <= s2 ? R_IDLE : R_DATA;
              end
            R_DATA:
              if (rcnt == BIT_CYC - 1)
              begin
                rcnt <= 16'h0000;
                rsh  <= {s2, rsh[7:1]};
                rbit <= rbit + 3'h1;
                rbad <= 1'b0;
                if (rbit == 3'h7)
                  rst <= R_STOP;
              end
            R_STOP:
            begin
              // the whole stop bit is watched, not only its middle
              if (rcnt >= HALF_CYC && !s2)
                rbad <= 1'b1;
              if (rcnt == BIT_CYC + HALF_CYC - 2)
              begin
                rdone <= 1'b1;
                rferr <= rbad | ~s2;
                rst   <= R_IDLE;
              end
            end
            default:
              rst <= R_IDLE;
          endcase
          if (!tbusy)
          begin
            tcnt <= 16'h0000;
            tidx <= 4'h0;
            if (tx_go[ch])
            begin
              tsh   <= {1'b1, tx_byte[ch*8 +: 8], 1'b0};
              tbusy <= 1'b1;
            end
          end
          else if (tcnt == BIT_CYC - 1)
          begin
            tcnt <= 16'h0000;
            tsh  <= {1'b1, tsh[9:1]};
            tidx <= tidx + 4'h1;
            if (tidx == 4'h9)
              tbusy <= 1'b0;
          end
          else
            tcnt <= tcnt + 16'h0001;
        end
      end
      assign rx_done[ch]        = rdone;
      assign rx_ferr[ch]        = rferr;
      assign rx_byte[ch*8 +: 8] = rsh;
      assign tx_busy[ch]        = tbusy;
      assign tx_line[ch]        = tsh[0];
    end
  endgenerate

  assign app_txd = tx_line[0];
  assign dbg_txd = tx_line[1];

  // ==========================================================
  // strap capture, prescaler and mode sequencer
  reg  [3:0]  sw_a1;
  reg  [3:0]  sw_a2;
  reg  [3:0]  sw_b1;
  reg  [3:0]  sw_b2;
  reg  [1:0]  sync_cnt;
  reg  [2:0]  state;
  reg  [31:0] wait_cnt;
  reg  [31:0] tick_cnt;
  reg         tick;
  wire        is_test = (state == M_TEST);
  wire        is_cfg  = (state == M_CFG);

  assign mode = state;

  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sw_a1    <= 4'h0;
      sw_a2    <= 4'h0;
      sw_b1    <= 4'h0;
      sw_b2    <= 4'h0;
      sync_cnt <= 2'h0;
      state    <= M_SYNC;
      wait_cnt <= 32'h00000000;
      tick_cnt <= 32'h00000000;
      tick     <= 1'b0;
      dbg_go   <= 1'b0;
    end
    else
    begin
      sw_a1    <= mode_switch_a;
      sw_a2    <= sw_a1;
      sw_b1    <= mode_switch_b;
      sw_b2    <= sw_b1;
      dbg_go   <= 1'b0;
      tick     <= (tick_cnt == TICK_CYC - 1);
      tick_cnt <= (tick_cnt == TICK_CYC - 1) ? 32'h00000000 : tick_cnt + 32'h00000001;
      // once left, the sequencer never returns to a deciding state
      case (state)
        M_SYNC:
          if (sync_cnt == `GMC_SYNC_CYC)
          begin
            if (sw_a2 == `GMC_SW_CONFIG && sw_b2 == `GMC_SW_CONFIG)
              state <= M_CFG;
            else if (sw_a2 == `GMC_SW_TEST && sw_b2 == `GMC_SW_TEST)
              state <= M_TEST;
            else
              state <= M_HELLO;
          end
          else
            sync_cnt <= sync_cnt + 2'h1;
        M_HELLO:
        begin
          dbg_go   <= 1'b1;
          wait_cnt <= 32'h00000000;
          state    <= M_WAIT;
        end
        M_WAIT:
          if (rx_done[1] && rx_byte[15:8] == `GMC_ACK_BYTE)
            state <= M_DEBUG;
          else if (wait_cnt == WAIT_CYC - 1)
            state <= M_DATA;
          else
            wait_cnt <= wait_cnt + 32'h00000001;
        M_CFG,
        M_TEST,
        M_DATA,
        M_DEBUG:
          state <= state;
        default:
          state <= M_SYNC;
      endcase
    end
  end

  // ==========================================================
  // test counters, fieldbus echo, indicators
  reg [3:0] tval;
  reg [7:0] tcnt255;
  reg [3:0] tcnt9;
  reg       tick_pend;
  reg       ferr;
  reg       fchk_en;

  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tval                    <= 4'h0;
      tcnt255                 <= 8'h00;
      tcnt9                   <= 4'h0;
      fb_out_valid            <= 1'b0;
      fb_out_byte0            <= 8'h00;
      error_number_indicators <= 4'h0;
      serial_status_indicator <= 1'b0;
      script_run              <= 1'b0;
    end
    else
    begin
      fb_out_valid <= 1'b0;
      script_run   <= (state == M_DATA);
      if (is_test && tick)
      begin
        tval         <= tval + 4'h1;
        tcnt255      <= tcnt255 + 8'h01;
        tcnt9        <= (tcnt9 == 4'h9) ? 4'h0 : tcnt9 + 4'h1;
        fb_out_byte0 <= {4'h0, tval};
        fb_out_valid <= 1'b1;
      end
      else if (is_test && fb_in_valid)
      begin
        fb_out_byte0 <= fb_in_byte0;
        fb_out_valid <= 1'b1;
      end
      if ((is_cfg || is_test) && tick)
        serial_status_indicator <= ~serial_status_indicator;
      else if (!(is_cfg || is_test))
        serial_status_indicator <= 1'b0;
      // tval already points one past the value on the line, and a fieldbus echo
      // must not disturb what the indicators show
      if (is_test)
      begin
        if (tick_pend)
          error_number_indicators <= tval - 4'h1;
      end
      else if (ferr)
        error_number_indicators <= `GMC_FERR_CODE;
      else
        error_number_indicators <= 4'h0;
    end
  end

  // ==========================================================
  // ethernet echo capture and reply
  reg [7:0] eth_keep [0:`GMC_ETH_ECHO-1];
  reg [2:0] eth_idx;
  wire [2:0] eth_pos = eth_rx_sof ? 3'h0 : eth_idx;
  integer i;

  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      eth_idx   <= 3'h0;
      eth_reply <= 64'h0000000000000000;
      for (i = 0; i < `GMC_ETH_ECHO; i = i + 1)
        eth_keep[i] <= 8'h00;
    end
    else
    begin
      if (eth_rx_valid && eth_pos < `GMC_ETH_ECHO)
      begin
        eth_keep[eth_pos] <= eth_rx_data;
        eth_idx           <= eth_pos + 3'h1;
      end
      if (is_cfg)
        eth_reply <= {EXT_VER, `GMC_REPLY_FILL, eth_keep[3], 8'h00,
                      eth_keep[1], eth_keep[0]};
      else if (is_test)
        eth_reply <= {4'h0, tcnt9, tcnt255, eth_keep[5], eth_keep[4], eth_keep[3],
                      eth_keep[2], eth_keep[1], eth_keep[0]};
      else
        eth_reply <= 64'h0000000000000000;
    end
  end

  assign eth_tcp_port    = `GMC_TCP_PORT;
  assign eth_udp_scan_en = ~is_test & ~eth_ftp_connected;

  // ==========================================================
  // serial buffers and register slave
  reg  [7:0]  rx_mem [0:(1<<`GMC_BUF_AW)-1];
  reg  [7:0]  tx_mem [0:(1<<`GMC_BUF_AW)-1];
  reg  [10:0] rx_wp;
  reg  [10:0] rx_rp;
  reg  [10:0] tx_wp;
  reg  [10:0] tx_rp;
  reg         ack;
  wire        rx_empty = (rx_wp == rx_rp);
  wire        rx_full  = (rx_wp - rx_rp) == 11'h400;
  wire        tx_empty = (tx_wp == tx_rp);
  wire        tx_full  = (tx_wp - tx_rp) == 11'h400;
  wire        req      = avs_read | avs_write;
  wire        take     = req & ~ack;
  wire        bus_push = take & avs_write & avs_byteenable[0]
                         & (avs_address == `GMC_REG_TXDATA) & (state == M_DATA);
  wire        echo     = is_test & rx_done[0];
  reg         push;
  reg  [7:0]  push_byte;

  assign avs_waitrequest = req & ~ack;

  // echo beats the tick; a tick waits one cycle rather than being lost
  always @*
  begin
    push      = 1'b0;
    push_byte = 8'h00;
    if (echo)
    begin
      push      = 1'b1;
      push_byte = rx_byte[7:0];
    end
    else if (is_test && tick_pend)
    begin
      push      = 1'b1;
      push_byte = hex_ascii(tval - 4'h1);
    end
    else if (bus_push)
    begin
      push      = 1'b1;
      push_byte = avs_writedata[7:0];
    end
  end

  always @(posedge core_clk)
  begin
    if (push && !tx_full)
      tx_mem[tx_wp[9:0]] <= push_byte;
    if (rx_done[0] && state == M_DATA && !rx_full)
      rx_mem[rx_wp[9:0]] <= rx_byte[7:0];
  end

  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_wp        <= 11'h000;
      rx_rp        <= 11'h000;
      tx_wp        <= 11'h000;
      tx_rp        <= 11'h000;
      app_go       <= 1'b0;
      app_tx_byte  <= 8'h00;
      tick_pend    <= 1'b0;
      ack          <= 1'b0;
      avs_readdata <= 32'h00000000;
      fchk_en      <= `GMC_CTRL_RESET;
      ferr         <= 1'b0;
    end
    else
    begin
      // tval steps one past fb_out_byte0 on the tick, so the push is delayed a cycle and sends tval - 1
      tick_pend <= is_test & tick | (tick_pend & echo);
      if (push && !tx_full)
        tx_wp <= tx_wp + 11'h001;
      if (rx_done[0] && state == M_DATA && !rx_full)
        rx_wp <= rx_wp + 11'h001;
      app_go <= ~tx_busy[0] & ~app_go & ~tx_empty;
      if (!tx_busy[0] && !app_go && !tx_empty)
      begin
        app_tx_byte <= tx_mem[tx_rp[9:0]];
        tx_rp        <= tx_rp + 11'h001;
      end
      ack <= take;
      if (take && avs_read)
      begin
        case (avs_address)
          `GMC_REG_CTRL:
            avs_readdata <= {31'h00000000, fchk_en};
          `GMC_REG_STATUS:
            avs_readdata <= {26'h0000000, tx_full, rx_empty, ferr, state};
          `GMC_REG_RXDATA:
            avs_readdata <= {24'h000000, rx_empty ? 8'h00 : rx_mem[rx_rp[9:0]]};
          default:
            avs_readdata <= 32'h00000000;
        endcase
        if (avs_address == `GMC_REG_RXDATA && !rx_empty)
          rx_rp <= rx_rp + 11'h001;
      end
      if (take && avs_write && avs_byteenable[0] && avs_address == `GMC_REG_CTRL)
        fchk_en <= avs_writedata[`GMC_CTRL_FCHK];
      // a new framing error wins over a clear in the same cycle
      if (rx_ferr[0] && fchk_en && FMT_8N1)
        ferr <= 1'b1;
      else if (take && avs_write && avs_byteenable[0]
               && avs_address == `GMC_REG_STATUS && avs_writedata[`GMC_ST_FERR])
        ferr <= 1'b0;
    end
  end

endmodule // gmc_top

// ---- verification/gmc_assertions.sv ----
`timescale 1ns/10ps
// ==========================================
// checker on the top ports
module gmc_checker #(
  parameter [23:0] EXT_VER = 24'h010203
) (
  input wire        core_clk,
  input wire        arst_n,
  input wire [2:0]  mode,
  input wire        script_run,
  input wire        fb_in_valid,
  input wire        fb_out_valid,
  input wire [7:0]  fb_out_byte0,
  input wire [3:0]  error_number_indicators,
  input wire [63:0] eth_reply,
  input wire [15:0] eth_tcp_port,
  input wire        eth_ftp_connected,
  input wire        eth_udp_scan_en
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  // ==========================================
  // test mode
  // an echo the cycle before is left out, it may share the output with a tick
  sequence s_tick;
    mode == 3'h2 && fb_out_valid && !$past(fb_in_valid);
  endsequence
  sequence s_show;
    fb_out_byte0 < 8'h10 ##1 error_number_indicators == $past(fb_out_byte0[3:0]);
  endsequence
  property p_tick;
    s_tick |-> s_show;
  endproperty
  a_tick: assert property (p_tick)
    else $error("tick value not shown");
  property p_seventh;
    mode == 3'h2 && $changed(eth_reply[55:48]) |->
      eth_reply[55:48] == $past(eth_reply[55:48]) + 8'h01 && $changed(eth_reply[63:56]);
  endproperty
  a_seventh: assert property (p_seventh)
    else $error("seventh byte step wrong");
  property p_eighth;
    mode == 3'h2 |-> eth_reply[63:56] <= 8'h09;
  endproperty
  a_eighth: assert property (p_eighth)
    else $error("eighth byte out of range");
  property p_echo;
    mode == 3'h2 && fb_in_valid |=> fb_out_valid;
  endproperty
  a_echo: assert property (p_echo)
    else $error("fieldbus echo missing");
  property p_port;
    mode == 3'h2 |-> eth_tcp_port == 16'h0017;
  endproperty
  a_port: assert property (p_port)
    else $error("test port wrong");

  // ==========================================
  // other modes
  property p_cfg;
    mode == 3'h1 && eth_reply != 64'h0 |->
      eth_reply[63:32] == {EXT_VER, 8'hFF} && eth_reply[23:16] == 8'h00;
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("config reply format wrong");
  property p_udp;
    eth_ftp_connected |-> !eth_udp_scan_en;
  endproperty
  a_udp: assert property (p_udp)
    else $error("scan channel kept after ftp");
  property p_run;
    mode == 3'h3 |-> ##[0:1] script_run;
  endproperty
  a_run: assert property (p_run)
    else $error("script not running");
  property p_stop;
    mode == 3'h4 |-> !script_run;
  endproperty
  a_stop: assert property (p_stop)
    else $error("script runs in debug");
  property p_hold;
    mode inside {3'h1, 3'h2, 3'h3, 3'h4} |=> $stable(mode);
  endproperty
  a_hold: assert property (p_hold)
    else $error("mode changed after decision");
  property p_dbg;
    $changed(mode) && mode == 3'h4 |-> $past(mode) == 3'h6;
  endproperty
  a_dbg: assert property (p_dbg)
    else $error("debug entered without handshake");
endmodule  // gmc_checker

bind gmc_top gmc_checker #(.EXT_VER(EXT_VER)) u_gmc_checker (
  .core_clk(core_clk), .arst_n(arst_n), .mode(mode), .script_run(script_run),
  .fb_in_valid(fb_in_valid), .fb_out_valid(fb_out_valid), .fb_out_byte0(fb_out_byte0),
  .error_number_indicators(error_number_indicators), .eth_reply(eth_reply),
  .eth_tcp_port(eth_tcp_port), .eth_ftp_connected(eth_ftp_connected),
  .eth_udp_scan_en(eth_udp_scan_en)
);

// ---- verification/gmc_host.sv ----
`timescale 1ns/10ps
// ==========================================
// serial host on the application and debug lines
module gmc_host #(
  parameter BIT_CYC = 16
) (
  input  wire core_clk,
  input  wire app_txd,
  input  wire dbg_txd,
  output reg  app_rxd,
  output reg  dbg_rxd
);
  logic [7:0] app_q[$];
  logic [7:0] dbg_q[$];
  logic       ack_en;
  logic [7:0] a_b;
  logic [7:0] d_b;

  initial
  begin
    app_rxd = 1'b1;
    dbg_rxd = 1'b1;
    ack_en  = 1'b0;
  end

  // 8N1 lsb first, no flow control; a short stop drops low for the rest of its bit
  task automatic send(input logic dbg, input logic [7:0] b, input int stop_cyc);
    logic [9:0] f;
    logic       v;
    int         n;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 11 * BIT_CYC; i++)
    begin
      @(posedge core_clk);
      n = i / BIT_CYC;
      v = (n > 9) ? 1'b1 : (n == 9) ? (i % BIT_CYC < stop_cyc) : f[n];
      if (dbg)
        dbg_rxd <= v;
      else
        app_rxd <= v;
    end
  endtask

  task automatic grab(input logic dbg, output logic [7:0] b);
    b = 8'h00;
    repeat (BIT_CYC / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CYC) @(posedge core_clk);
      b[i] = dbg ? dbg_txd : app_txd;
    end
    repeat (BIT_CYC) @(posedge core_clk);
  endtask

  always
  begin
    @(negedge app_txd);
    grab(1'b0, a_b);
    app_q.push_back(a_b);
  end

  always
  begin
    @(negedge dbg_txd);
    grab(1'b1, d_b);
    dbg_q.push_back(d_b);
    if (ack_en && d_b == 8'h00)
      send(1'b1, 8'h4F, BIT_CYC);
  end
endmodule  // gmc_host

// ---- verification/tb_gateway_mode_controller.sv ----
`timescale 1ns/10ps
module tb_gateway_mode_controller;
  localparam BIT_CYC  = 16;
  localparam TICK_CYC = 2000;
  localparam WAIT_CYC = 2000;
  localparam [23:0] EXT_VER = 24'h010203;  // arbitrary value
  logic        core_clk, arst_n, avs_read, avs_write, avs_waitrequest;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0]  avs_byteenable, mode_switch_a, mode_switch_b, error_number_indicators;
  logic        app_rxd, app_txd, dbg_rxd, dbg_txd, fb_in_valid, fb_out_valid;
  logic [7:0]  fb_in_byte0, fb_out_byte0, eth_rx_data, b8;
  logic        eth_rx_valid, eth_rx_sof, eth_ftp_connected, eth_udp_scan_en, l;
  logic [63:0] eth_reply;
  logic [15:0] eth_tcp_port;
  logic        serial_status_indicator, script_run;
  logic [2:0]  mode;
  logic [7:0]  r[8];
  int          mismatches, checked, seed, cyc;

  gmc_top #(.BIT_CYC(BIT_CYC), .TICK_CYC(TICK_CYC), .WAIT_CYC(WAIT_CYC), .EXT_VER(EXT_VER))
    u_gmc_top (.*);
  gmc_host #(.BIT_CYC(BIT_CYC)) u_gmc_host (.*);

  always #5 core_clk = ~core_clk;

  // ==========================================
  // hang guard
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  // ==========================================
  // helpers
  task automatic tally_and_finish();
    if (mismatches == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] hexc(input int k);
    return (k < 10) ? 8'h30 + 8'(k) : 8'h37 + 8'(k);
  endfunction

  // switches must already be settled when reset lets go
  task automatic power_up(input logic [3:0] sa, input logic [3:0] sb);
    @(posedge core_clk);
    arst_n        <= 1'b0;
    mode_switch_a <= sa;
    mode_switch_b <= sb;
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    u_gmc_host.app_q.delete();
    u_gmc_host.dbg_q.delete();
  endtask

  task automatic mode_wait(input logic [2:0] m);
    for (int i = 0; i < 5000 && mode !== m; i++)
      @(negedge core_clk);
    chk("mode", m, mode);
  endtask

  task automatic app_byte(input logic [7:0] e);
    for (int i = 0; i < 400 && u_gmc_host.app_q.size() == 0; i++)
      @(negedge core_clk);
    chk("app byte", e, u_gmc_host.app_q.size() ? u_gmc_host.app_q.pop_front() : 8'hXX);
  endtask

  // held until the rising edge that sees waitrequest low; data taken there, then released
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= d;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge core_clk);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic eth_frame(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge core_clk);
      r[i] = 8'($random(seed));
      eth_rx_valid <= 1'b1;
      eth_rx_sof   <= (i == 0);
      eth_rx_data  <= r[i];
    end
    @(posedge core_clk);
    eth_rx_valid <= 1'b0;
    repeat (3) @(negedge core_clk);
  endtask

  // the low tail of a short stop ends as the stop check does, so it is not taken as a start; wait past it anyway
  task automatic bad_stop();
    u_gmc_host.send(1'b0, 8'($random(seed)), BIT_CYC / 4);
    repeat (12 * BIT_CYC) @(negedge core_clk);
  endtask

  // ==========================================
  // main sequence
  initial
  begin
    seed = 17891;
    core_clk = 1'b0;
    arst_n = 1'b0;
    {avs_read, avs_write, fb_in_valid, eth_rx_valid, eth_rx_sof, eth_ftp_connected} = 6'h00;
    avs_address = 5'h00;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
    fb_in_byte0 = 8'h00;
    eth_rx_data = 8'h00;
    mode_switch_a = 4'h0;
    mode_switch_b = 4'h0;
    power_up(4'hF, 4'hF);
    mode_wait(3'h1);
    chk("script_run", 1'b0, script_run);
    eth_frame(4);
    chk("cfg reply", {EXT_VER, 8'hFF, r[3], 8'h00, r[1], r[0]}, eth_reply);
    @(posedge core_clk);
    eth_ftp_connected <= 1'b1;
    @(negedge core_clk);
    chk("udp scan", 1'b0, eth_udp_scan_en);
    @(posedge core_clk);
    eth_ftp_connected <= 1'b0;
    @(negedge core_clk);
    chk("udp scan", 1'b1, eth_udp_scan_en);
    chk("tcp port", 16'h0017, eth_tcp_port);
    l = serial_status_indicator;
    repeat (TICK_CYC) @(negedge core_clk);
    chk("status led", !l, serial_status_indicator);
    power_up(4'hE, 4'hE);
    mode_wait(3'h2);
    eth_frame(8);
    chk("test echo", {r[5], r[4], r[3], r[2], r[1], r[0]}, eth_reply[47:0]);
    for (int k = 0; k < 4; k++)
    begin
      for (int i = 0; i < TICK_CYC + 100 && fb_out_valid !== 1'b1; i++)
        @(negedge core_clk);
      chk("tick value", k, fb_out_byte0);
      @(negedge core_clk);
      chk("indicators", k, error_number_indicators);
      app_byte(hexc(k));
      b8 = 8'($random(seed));
      @(posedge core_clk);
      fb_in_valid <= 1'b1;
      fb_in_byte0 <= b8;
      @(posedge core_clk);
      fb_in_valid <= 1'b0;
      @(negedge core_clk);
      chk("fb echo", {1'b1, b8}, {fb_out_valid, fb_out_byte0});
      chk("indicators", k, error_number_indicators);
      u_gmc_host.send(1'b0, b8, BIT_CYC);
      app_byte(b8);
      chk("eighth", eth_reply[55:48] % 8'h0A, eth_reply[63:56]);
    end
    chk("test port", 16'h0017, eth_tcp_port);
    u_gmc_host.ack_en = 1'b1;
    power_up({1'b0, 3'($random(seed))}, 4'($random(seed)));
    mode_wait(3'h4);
    chk("hello", 8'h00, u_gmc_host.dbg_q[0]);
    chk("script_run", 1'b0, script_run);
    u_gmc_host.ack_en = 1'b0;
    power_up({1'b0, 3'($random(seed))}, 4'($random(seed)));
    mode_wait(3'h3);
    @(negedge core_clk);
    chk("script_run", 1'b1, script_run);
    bus(1'b0, 5'h00, 32'h00000000);
    chk("ctrl", 32'h00000001, q);
    bus(1'b0, 5'h04, 32'h00000000);
    chk("status", 32'h00000013, q);
    bus(1'b0, 5'h10, 32'h00000000);
    chk("unmapped", 32'h00000000, q);
    b8 = 8'($random(seed));
    u_gmc_host.send(1'b0, b8, BIT_CYC);
    repeat (2 * BIT_CYC) @(negedge core_clk);
    bus(1'b0, 5'h08, 32'h00000000);
    chk("rxdata", {24'h000000, b8}, q);
    b8 = 8'($random(seed));
    bus(1'b1, 5'h0C, {24'h000000, b8});
    app_byte(b8);
    bad_stop();
    chk("ferr leds", 4'h1, error_number_indicators);
    bus(1'b0, 5'h04, 32'h00000000);
    chk("ferr", 1'b1, q[3]);
    bus(1'b1, 5'h04, 32'h00000008);
    bus(1'b1, 5'h00, 32'h00000000);
    bad_stop();
    bus(1'b0, 5'h04, 32'h00000000);
    chk("ferr off", 1'b0, q[3]);
    tally_and_finish();
  end
endmodule  // tb_gateway_mode_controller
